/* File: wdt_pkg.sv */
// shared constants and types of the low-power watchdog
package wdt_pkg;
	// control register field positions
	localparam int H_SRC_BIT = 7;
	localparam int STOP_FUNC_BIT = 6;
	localparam int READ_UPPER_LSB = 2;
	// counter stage geometry and reload value
	localparam int STAGE_WIDTH = 8;
	localparam logic [7:0] STAGE_RELOAD = 8'hff;
	// external clock divider feeding the upper stage when selected
	localparam int EXT_DIVIDE = 16;
	localparam int PRESC_WIDTH = 4;
	localparam logic [3:0] PRESC_LAST = 4'hf;
	localparam logic [3:0] PRESC_RESET = 4'h0;
	// reset values of control bits
	localparam logic H_SRC_RESET = 1'b0;
	localparam logic STOP_FUNC_RESET = 1'b0;
	localparam logic CPU_EXT_RESET = 1'b0;
	// power mode of the device as seen by the watchdog
	typedef enum logic {
		MODE_RUN,
		MODE_STOP
	} power_mode_t;
endpackage : wdt_pkg

/* File: wdt_stage.sv */
// one down-counting stage of the watchdog with reload and underflow pulse
`timescale 1ns/10ps
module wdt_stage #(
	parameter int WIDTH = 8
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic load,
	input wire logic dec,
	output logic [WIDTH-1:0] count,
	output logic underflow
);
	typedef struct packed {
		logic [WIDTH-1:0] count;
	} stage_state_t;

	stage_state_t st_reg;
	stage_state_t st_next;

	// -----------------------------------------------------------------
	// elaboration check
	// -----------------------------------------------------------------
	if (WIDTH < 3) begin : g_width_check
		$error("wdt_stage WIDTH must be at least 3");
	end

	// wrap from zero is the underflow; load overrides a pending tick
	assign underflow = dec && !load && (st_reg.count == '0); // RULE15

	// next count: reload to all ones, else decrement on the tick
	always_comb begin
		st_next = st_reg;
		if (load) begin
			st_next.count = '1; // RULE11
		end else if (dec) begin
			st_next.count = st_reg.count - 1'b1; // RULE15
		end
	end

	// reset leaves the stage at all ones
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			st_reg <= '{count: '1};
		end else begin
			st_reg <= st_next;
		end
	end

	assign count = st_reg.count;

	// -----------------------------------------------------------------
	// assertions
	// -----------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);

	property p_stage_wrap;
		(dec && !load && count == '0) |=> (count == '1);
	endproperty
	a_stage_wrap: assert property (p_stage_wrap) else $error("stage did not wrap to ones"); // RULE15
endmodule : wdt_stage

/* File: watchdog_timer_low_power.sv */
// watchdog timer: two cascaded stages, stop-mode handling and clock source choice
`timescale 1ns/10ps
// Operation
// RULE1: counter keeps running in wait mode, so underflow reset stays possible.
// RULE2: software keeps writing the control register in wait mode to avoid underflow.
// RULE3: counter holds its value, without decrementing, while in stop mode.
// RULE4: counting resumes as soon as stop mode is left, during oscillator settling.
// RULE5: software reloads the counter by a write just before the stop instruction.
// RULE6: stop behaviour bit 6 takes exactly one write after reset; later writes ignored.
// RULE7: count source follows cpu clock selection; external clock when selected.
// RULE8: on-chip oscillator feeds the watchdog when it is the cpu clock.
// RULE9: after reset the cpu clock is the on-chip oscillator.
// RULE10: software switches to external clock only after supply and oscillation settle.
// RULE11: reset or any control write loads both stages with all ones.
// RULE12: upper stage underflow forces internal reset; idle until first control write.
// RULE13: bit 7 picks upper source: lower underflow or external clock by 16.
// RULE14: stop instruction enters stop mode if bit 6 is 0, else internal reset.
// RULE15: lower stage decrements per watchdog tick, pulsing underflow on wrap.
module watchdog_timer_low_power (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic ctrlWrite,
	input wire logic [wdt_pkg::STAGE_WIDTH-1:0] ctrlWriteData,
	output logic [wdt_pkg::STAGE_WIDTH-1:0] ctrlReadData,
	input wire logic cpuModeWrite,
	input wire logic cpuModeClkExternal,
	output logic cpuClockExternal,
	input wire logic tickExternal,
	input wire logic tickOnChip,
	input wire logic stopInstruction,
	input wire logic stopRelease,
	output logic stopModeActive,
	output logic internalReset
);
	import wdt_pkg::*;

	typedef struct packed {
		logic started;
		logic hSrcSel;
		logic stopFunc;
		logic stopFuncLocked;
		power_mode_t mode;
		logic cpuExt;
		logic [PRESC_WIDTH-1:0] presc;
		logic resetPulse;
	} wdt_state_t;

	localparam wdt_state_t RESET_STATE = '{
		started: 1'b0,
		hSrcSel: H_SRC_RESET,
		stopFunc: STOP_FUNC_RESET,
		stopFuncLocked: 1'b0,
		mode: MODE_RUN,
		cpuExt: CPU_EXT_RESET,
		presc: PRESC_RESET,
		resetPulse: 1'b0
	};

	wdt_state_t st_reg;
	wdt_state_t st_next;
	logic [STAGE_WIDTH-1:0] lowerCount;
	logic [STAGE_WIDTH-1:0] upperCount;
	logic lowerUnderflow;
	logic upperUnderflow;
	logic stageLoad;
	logic running;
	logic wdtTick;
	logic extDiv16;
	logic upperDec;

	// -----------------------------------------------------------------
	// elaboration check
	// -----------------------------------------------------------------
	if (EXT_DIVIDE != (1 << PRESC_WIDTH)) begin : g_div_check
		$error("external divider must match prescaler width");
	end

	// -----------------------------------------------------------------
	// count source and stage chaining
	// -----------------------------------------------------------------
	// tick source tracks the cpu clock choice; wait mode gates nothing here
	assign wdtTick = st_reg.cpuExt ? tickExternal : tickOnChip; // RULE7 RULE8
	// held in stop mode and before the first control write, so wait mode still counts toward reset
	assign running = st_reg.started && (st_reg.mode == MODE_RUN); // RULE1 RULE3 RULE4
	// a self-reset reloads too, since the stages have no reset of their own from it
	assign stageLoad = ctrlWrite || st_reg.resetPulse; // RULE11
	// divide-by-16 is taken from the external clock regardless of cpu clock
	assign extDiv16 = tickExternal && (st_reg.presc == PRESC_LAST);
	assign upperDec = running && (st_reg.hSrcSel ? extDiv16 : lowerUnderflow); // RULE13

	wdt_stage #(
		.WIDTH(STAGE_WIDTH)
	) u_lower (
		.clk(clk),
		.reset_n(reset_n),
		.load(stageLoad),
		.dec(running && wdtTick), // RULE15
		.count(lowerCount),
		.underflow(lowerUnderflow)
	);

	wdt_stage #(
		.WIDTH(STAGE_WIDTH)
	) u_upper (
		.clk(clk),
		.reset_n(reset_n),
		.load(stageLoad),
		.dec(upperDec),
		.count(upperCount),
		.underflow(upperUnderflow)
	);

	// -----------------------------------------------------------------
	// control state
	// -----------------------------------------------------------------
	// internal reset returns every control bit to its reset value
	always_comb begin
		st_next = st_reg;
		st_next.resetPulse = 1'b0;
		if (st_reg.resetPulse) begin
			st_next = RESET_STATE; // RULE9 RULE12
		end else begin
			if (tickExternal) begin
				st_next.presc = st_reg.presc + 1'b1;
			end
			if (cpuModeWrite) begin
				st_next.cpuExt = cpuModeClkExternal;
			end
			if (ctrlWrite) begin
				st_next.started = 1'b1; // RULE12
				st_next.hSrcSel = ctrlWriteData[H_SRC_BIT]; // RULE13
				// only the first write after reset reaches the stop behaviour bit
				if (!st_reg.stopFuncLocked) begin
					st_next.stopFunc = ctrlWriteData[STOP_FUNC_BIT]; // RULE6
					st_next.stopFuncLocked = 1'b1; // RULE6
				end
			end
			unique case (st_reg.mode)
				MODE_RUN: begin
					if (stopInstruction && st_reg.stopFunc) begin
						st_next.resetPulse = 1'b1; // RULE14
					end else if (stopInstruction) begin
						st_next.mode = MODE_STOP; // RULE14
					end
				end
				MODE_STOP: begin
					if (stopRelease) begin
						st_next.mode = MODE_RUN; // RULE4
					end
				end
			endcase
			if (upperUnderflow) begin
				st_next.resetPulse = 1'b1; // RULE12
			end
		end
	end

	// single state register
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			st_reg <= RESET_STATE;
		end else begin
			st_reg <= st_next;
		end
	end

	// -----------------------------------------------------------------
	// outputs
	// -----------------------------------------------------------------
	// read view: source bit, stop bit, then the top six bits of the upper stage
	assign ctrlReadData = {st_reg.hSrcSel, st_reg.stopFunc,
		upperCount[STAGE_WIDTH-1:READ_UPPER_LSB]};
	assign cpuClockExternal = st_reg.cpuExt;
	assign stopModeActive = (st_reg.mode == MODE_STOP);
	assign internalReset = st_reg.resetPulse;

	// -----------------------------------------------------------------
	// assertions
	// -----------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);

	sequence s_stop_taken;
		stopInstruction && !st_reg.stopFunc && !stopModeActive && !st_reg.resetPulse;
	endsequence

	sequence s_plain_tick;
		running && wdtTick && !stageLoad;
	endsequence

	property p_write_reload;
		ctrlWrite |=> (lowerCount == STAGE_RELOAD) && (upperCount == STAGE_RELOAD);
	endproperty
	a_write_reload: assert property (p_write_reload) else $error("write did not reload"); // RULE11

	property p_stop_hold;
		(stopModeActive && !stageLoad) |=> $stable(lowerCount) && $stable(upperCount);
	endproperty
	a_stop_hold: assert property (p_stop_hold) else $error("counter moved in stop"); // RULE3

	property p_stop_enter;
		s_stop_taken |=> stopModeActive && !internalReset;
	endproperty
	a_stop_enter: assert property (p_stop_enter) else $error("stop mode not entered"); // RULE14

	property p_stop_reset;
		(stopInstruction && st_reg.stopFunc && !stopModeActive && !st_reg.resetPulse)
			|=> internalReset ##1 !internalReset;
	endproperty
	a_stop_reset: assert property (p_stop_reset) else $error("stop did not reset"); // RULE14

	property p_resume;
		(stopModeActive && stopRelease && !st_reg.resetPulse) |=> !stopModeActive;
	endproperty
	a_resume: assert property (p_resume) else $error("stop not released"); // RULE4

	property p_lock;
		(st_reg.stopFuncLocked && ctrlWrite && !st_reg.resetPulse) |=> $stable(st_reg.stopFunc);
	endproperty
	a_lock: assert property (p_lock) else $error("stop bit changed twice"); // RULE6

	property p_underflow_reset;
		upperUnderflow |=> internalReset ##1 (lowerCount == STAGE_RELOAD) && !running;
	endproperty
	a_underflow_reset: assert property (p_underflow_reset) else $error("no reset on underflow"); // RULE12

	property p_idle;
		(!st_reg.started && !stageLoad) |=> $stable(lowerCount);
	endproperty
	a_idle: assert property (p_idle) else $error("counted before first write"); // RULE12

	property p_source;
		s_plain_tick |=> lowerCount == STAGE_WIDTH'($past(lowerCount) - 1'b1);
	endproperty
	a_source: assert property (p_source) else $error("lower stage missed tick"); // RULE7 RULE8

	property p_no_stray_tick;
		(running && !stageLoad && !(st_reg.cpuExt ? tickExternal : tickOnChip))
			|=> $stable(lowerCount);
	endproperty
	a_no_stray_tick: assert property (p_no_stray_tick) else $error("wrong tick source"); // RULE7 RULE8

	property p_upper_chain;
		(running && !st_reg.hSrcSel && lowerUnderflow && !stageLoad && upperCount != '0)
			|=> upperCount == STAGE_WIDTH'($past(upperCount) - 1'b1);
	endproperty
	a_upper_chain: assert property (p_upper_chain) else $error("upper stage missed carry"); // RULE13

	property p_boot_clock;
		internalReset |=> !cpuClockExternal && !st_reg.hSrcSel && !st_reg.stopFunc;
	endproperty
	a_boot_clock: assert property (p_boot_clock) else $error("reset state wrong"); // RULE9
endmodule : watchdog_timer_low_power

/* File: watchdog_timer_low_power_bench.sv */
// self-checking bench of the low-power watchdog timer
`timescale 1ns/10ps
module watchdog_timer_low_power_bench;
	import wdt_pkg::*;
	// ----------------------------------------
	// stimulus, observed signals and counters
	// ----------------------------------------
	localparam int ON_CHIP = 0;
	localparam int EXT = 1;
	localparam int STOP = 2;
	localparam int RELEASE = 3;
	localparam int MODE = 4;
	logic clk = 1'b0;
	logic reset_n = 1'b0;
	logic ctrlWrite = 1'b0;
	logic [STAGE_WIDTH-1:0] ctrlWriteData = 8'h00;
	logic [STAGE_WIDTH-1:0] ctrlReadData;
	logic cpuModeClkExternal = 1'b0;
	logic [4:0] strobes = 5'h00;
	logic cpuClockExternal;
	logic stopModeActive;
	logic internalReset;
	logic [7:0] resetPulses = 8'h00;
	int badCount = 0;
	int samplesChecked = 0;

	// clock of 50 MHz
	always #10 clk = ~clk;

	watchdog_timer_low_power uut (
		.clk(clk),
		.reset_n(reset_n),
		.ctrlWrite(ctrlWrite),
		.ctrlWriteData(ctrlWriteData),
		.ctrlReadData(ctrlReadData),
		.cpuModeWrite(strobes[MODE]),
		.cpuModeClkExternal(cpuModeClkExternal),
		.cpuClockExternal(cpuClockExternal),
		.tickExternal(strobes[EXT]),
		.tickOnChip(strobes[ON_CHIP]),
		.stopInstruction(strobes[STOP]),
		.stopRelease(strobes[RELEASE]),
		.stopModeActive(stopModeActive),
		.internalReset(internalReset)
	);

	// count reset requests; the pulse is only one cycle wide, so it is caught on exactly one edge
	always @(posedge clk) begin
		if (internalReset === 1'b1) begin
			resetPulses <= resetPulses + 8'h01;
		end
	end

	// ----------------------------------------
	// access tasks and comparisons
	// ----------------------------------------
	// strobes are spaced one idle cycle apart so each counts as a single tick
	task pulseIn(input int sel, input int n);
		repeat (n) begin
			@(negedge clk);
			strobes[sel] = 1'b1;
			@(negedge clk);
			strobes[sel] = 1'b0;
		end
	endtask : pulseIn

	task writeCtrl(input logic [7:0] data);
		@(negedge clk);
		ctrlWrite = 1'b1;
		ctrlWriteData = data;
		@(negedge clk);
		ctrlWrite = 1'b0;
	endtask : writeCtrl

	task checkByte(input string name, input logic [7:0] exp, input logic [7:0] got);
		samplesChecked++;
		if (got !== exp) begin
			badCount++;
			$display("mismatch %s expected %h seen %h", name, exp, got);
		end
	endtask : checkByte

	task checkBit(input string name, input logic exp, input logic got);
		samplesChecked++;
		if (got !== exp) begin
			badCount++;
			$display("mismatch %s expected %b seen %b", name, exp, got);
		end
	endtask : checkBit

	task results();
		$display("comparisons %0d mismatches %0d", samplesChecked, badCount);
		if (badCount == 0 && samplesChecked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : results

	// ----------------------------------------
	// test sequence
	// ----------------------------------------
	initial begin
		repeat (20) @(negedge clk);
		reset_n = 1'b1;
		@(negedge clk);
		checkByte("ctrlReadData", 8'h3f, ctrlReadData);
		checkBit("cpuClockExternal", 1'b0, cpuClockExternal);
		checkBit("stopModeActive", 1'b0, stopModeActive);
		pulseIn(ON_CHIP, 1024);
		checkByte("ctrlReadData", 8'h3f, ctrlReadData);
		writeCtrl(8'h00);
		checkByte("ctrlReadData", 8'h3f, ctrlReadData);
		// the first write already fixed the stop behaviour bit at 0
		writeCtrl(8'h40);
		checkByte("ctrlReadData", 8'h3f, ctrlReadData);
		pulseIn(EXT, 1024);
		checkByte("ctrlReadData", 8'h3f, ctrlReadData);
		// reload just before stop so the settling time after release cannot underflow
		writeCtrl(8'h00);
		pulseIn(STOP, 1);
		checkBit("stopModeActive", 1'b1, stopModeActive);
		pulseIn(ON_CHIP, 1024);
		checkByte("ctrlReadData", 8'h3f, ctrlReadData);
		pulseIn(RELEASE, 1);
		checkBit("stopModeActive", 1'b0, stopModeActive);
		// 1024 ticks give four lower wraps: upper goes from ff to fb
		pulseIn(ON_CHIP, 1024);
		checkByte("ctrlReadData", 8'h3e, ctrlReadData);
		writeCtrl(8'h00);
		checkByte("ctrlReadData", 8'h3f, ctrlReadData);
		cpuModeClkExternal = 1'b1;
		// external ticks have already run, so the oscillator counts as settled here
		pulseIn(MODE, 1);
		checkBit("cpuClockExternal", 1'b1, cpuClockExternal);
		pulseIn(ON_CHIP, 1024);
		checkByte("ctrlReadData", 8'h3f, ctrlReadData);
		pulseIn(EXT, 1024);
		checkByte("ctrlReadData", 8'h3e, ctrlReadData);
		writeCtrl(8'h80);
		checkByte("ctrlReadData", 8'hbf, ctrlReadData);
		// external ticks so far are a multiple of 16, so the divider phase is known
		pulseIn(EXT, 64);
		checkByte("ctrlReadData", 8'hbe, ctrlReadData);
		writeCtrl(8'h80);
		pulseIn(EXT, 4095);
		checkByte("resetPulses", 8'h00, resetPulses);
		pulseIn(EXT, 1);
		repeat (2) @(negedge clk);
		checkByte("resetPulses", 8'h01, resetPulses);
		checkByte("ctrlReadData", 8'h3f, ctrlReadData);
		checkBit("cpuClockExternal", 1'b0, cpuClockExternal);
		// after the internal reset the stop behaviour bit takes one write again
		writeCtrl(8'hc0);
		checkByte("ctrlReadData", 8'hff, ctrlReadData);
		writeCtrl(8'h00);
		checkByte("ctrlReadData", 8'h7f, ctrlReadData);
		pulseIn(STOP, 1);
		checkBit("stopModeActive", 1'b0, stopModeActive);
		@(negedge clk);
		checkByte("resetPulses", 8'h02, resetPulses);
		checkByte("ctrlReadData", 8'h3f, ctrlReadData);
		results();
	end

	// hang guard: the sequence needs about 20000 cycles
	initial begin
		repeat (60000) @(posedge clk);
		badCount++;
		results();
	end
endmodule : watchdog_timer_low_power_bench
